// File: include/kbc_pkg.sv
/*
  kbc_pkg: constants, command codes and state types of the keyboard and
  pointer controller command decoder.
  assumes one 10 MHz clock and a host that polls the status byte.
*/
// What this block does
// - pointer line-test command checks pointer clock and data, returns code
// - keyboard line-test command checks keyboard clock and data, returns code
// - test codes: 00 ok, 01/02 clock low/high, 03/04 data low/high
// - init command inhibits both interfaces and returns 55h
// - keyboard-disable command sets command byte bit 4
// - keyboard-enable command clears command byte bit 4
// - read-input-port command copies the input port to the output buffer
// - poll-high copies input bits 7..4 to status 7..4 until a new command
// - poll-low copies input bits 3..0 to status 3..0 until a new command
// - read-output-port command copies the output port to the output buffer
// - write-output-port takes the next data byte, changes only bit 1
// - keyboard echo returns next data byte as keyboard data, interrupt only if command byte bit 0 is set
// - pointer echo returns next data byte as pointer data, pointer interrupt only if command byte bit 1 is set
// - write-to-pointer sends the next data byte to the pointer, not keyboard
// - read-test-inputs places the two test inputs in output buffer bits 1..0
// - pulse commands: low nibble zero bits pulse output port bits 3..0
// - output port bit 0 is system reset; pulsing it resets the system
// - command port write loads input buffer and sets status bit 3
// - status bit 0 shows a full output buffer, cleared by data read
// - status bit 1 set by host write, cleared when the byte is taken
// - command byte bit 5 disables the pointer by holding its clock low
package kbc_pkg;
  // timing
  localparam int unsigned CLK_MHZ    = 10;
  localparam int unsigned SETTLE_US  = 10;
  localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int unsigned PULSE_US   = 6;
  localparam int unsigned PULSE_CYC  = PULSE_US * CLK_MHZ;
  // host commands
  localparam logic [7:0] CMD_PTEST = 8'hA9;
  localparam logic [7:0] CMD_INIT  = 8'hAA;
  localparam logic [7:0] CMD_KTEST = 8'hAB;
  localparam logic [7:0] CMD_KDIS  = 8'hAD;
  localparam logic [7:0] CMD_KEN   = 8'hAE;
  localparam logic [7:0] CMD_RDIN  = 8'hC0;
  localparam logic [7:0] CMD_POLLH = 8'hC2;
  localparam logic [7:0] CMD_POLLL = 8'hC3;
  localparam logic [7:0] CMD_RDOUT = 8'hD0;
  localparam logic [7:0] CMD_WROUT = 8'hD1;
  localparam logic [7:0] CMD_ECHOK = 8'hD2;
  localparam logic [7:0] CMD_ECHOP = 8'hD3;
  localparam logic [7:0] CMD_WRPNT = 8'hD4;
  localparam logic [7:0] CMD_RDTST = 8'hE0;
  localparam logic [3:0] CMD_PULSE = 4'hF;
  // answers
  localparam logic [7:0] LT_OK      = 8'h00;
  localparam logic [7:0] LT_CLK_LO  = 8'h01;
  localparam logic [7:0] LT_CLK_HI  = 8'h02;
  localparam logic [7:0] LT_DAT_LO  = 8'h03;
  localparam logic [7:0] LT_DAT_HI  = 8'h04;
  localparam logic [7:0] INIT_REPLY = 8'h55;
  // field positions
  localparam int CB_KBD_INT = 0;
  localparam int CB_PNT_INT = 1;
  localparam int CB_KBD_DIS = 4;
  localparam int CB_PNT_DIS = 5;
  localparam int ST_OBF     = 0;
  localparam int ST_IBF     = 1;
  localparam int ST_CD      = 3;
  localparam int OP_SYSRST  = 0;
  localparam int OP_GATE    = 1;
  // reset values
  localparam logic [7:0] CB_RST = 8'h00;
  localparam logic [7:0] OP_RST = 8'h0F;

  typedef enum logic [2:0] {
    PEND_NONE  = 3'b000,
    PEND_WROUT = 3'b001,
    PEND_ECHOK = 3'b010,
    PEND_ECHOP = 3'b011,
    PEND_WRPNT = 3'b100
  } pend_e;
  typedef enum logic [1:0] {
    POLL_OFF = 2'b00,
    POLL_HI  = 2'b01,
    POLL_LO  = 2'b10
  } poll_e;
  typedef enum logic {
    S_IDLE = 1'b0,
    S_TEST = 1'b1
  } ctl_e;
  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_REL  = 2'b01,
    T_DRV  = 2'b10
  } tst_e;

  function automatic logic cmd_known(input logic [7:0] c);
    case (c)
      CMD_PTEST, CMD_INIT, CMD_KTEST, CMD_KDIS, CMD_KEN, CMD_RDIN,
      CMD_POLLH, CMD_POLLL, CMD_RDOUT, CMD_WROUT, CMD_ECHOK,
      CMD_ECHOP, CMD_WRPNT, CMD_RDTST: cmd_known = 1'b1;
      default: cmd_known = (c[7:4] == CMD_PULSE);
    endcase
  endfunction
endpackage

// File: include/kbc_sub_if.sv
/*
  kbc_sub_if: links the decoder to its line tester and pulse generator.
  assumes all three sit on one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface kbc_sub_if;
  logic       test_go;
  logic       test_clk;
  logic       test_dat;
  logic       test_drv;
  logic       test_done;
  logic [7:0] test_code;
  logic       pulse_go;
  logic [3:0] pulse_sel;
  logic [3:0] pulse_act;
  modport ctl (output test_go, test_clk, test_dat, pulse_go, pulse_sel,
               input test_drv, test_done, test_code, pulse_act);
  modport tst (input test_go, test_clk, test_dat,
               output test_drv, test_done, test_code);
  modport pls (input pulse_go, pulse_sel, output pulse_act);
endinterface
`default_nettype wire

// File: logic/kbc_line_tester.sv
/*
  kbc_line_tester: checks one clock/data line pair for stuck levels.
  assumes the levels arrive already synchronised and that the caller
  routes test_drv onto both line enables during the test.
*/
`timescale 1ns/1ps
`default_nettype none
module kbc_line_tester #(
  parameter int unsigned SETTLE = kbc_pkg::SETTLE_CYC
)(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // decoder side
  kbc_sub_if.tst    sub
);
  import kbc_pkg::*;

  tst_e        st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic        done_reg, done_next;
  logic [7:0]  code_reg, code_next;
  logic        last;

  assign last = (cnt_reg == 16'(SETTLE - 1));

  // released phase finds stuck-low, driven phase finds stuck-high
  always_comb
  begin
    st_next   = st_reg;
    cnt_next  = cnt_reg + 16'h0001;
    done_next = 1'b0;
    code_next = code_reg;
    case (st_reg)
      T_IDLE:
      begin
        cnt_next = 16'h0000;
        if (sub.test_go)
          st_next = T_REL;
      end
      T_REL:
        if (last)
        begin
          cnt_next = 16'h0000;
          st_next  = T_DRV;
          if (!sub.test_clk)
          begin
            code_next = LT_CLK_LO;
            done_next = 1'b1;
            st_next   = T_IDLE;
          end
          else if (!sub.test_dat)
          begin
            code_next = LT_DAT_LO;
            done_next = 1'b1;
            st_next   = T_IDLE;
          end
        end
      T_DRV:
        if (last)
        begin
          done_next = 1'b1;
          st_next   = T_IDLE;
          if (sub.test_clk)
            code_next = LT_CLK_HI;
          else if (sub.test_dat)
            code_next = LT_DAT_HI;
          else
            code_next = LT_OK;
        end
      default: st_next = T_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg   <= T_IDLE;
      cnt_reg  <= 16'h0000;
      done_reg <= 1'b0;
      code_reg <= 8'h00;
    end
    else
    begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
      code_reg <= code_next;
    end
  end

  assign sub.test_drv  = (st_reg == T_DRV);
  assign sub.test_done = done_reg;
  assign sub.test_code = code_reg;
endmodule
`default_nettype wire

// File: logic/kbc_pulse_gen.sv
/*
  kbc_pulse_gen: times the output-port pulses.
  assumes pulse_sel bits set to 1 are the bits to pulse; a request
  while a pulse runs is dropped.
*/
`timescale 1ns/1ps
`default_nettype none
module kbc_pulse_gen #(
  parameter int unsigned WIDTH = kbc_pkg::PULSE_CYC
)(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // decoder side
  kbc_sub_if.pls    sub
);
  import kbc_pkg::*;

  logic [3:0]  act_reg, act_next;
  logic [15:0] cnt_reg, cnt_next;

  always_comb
  begin
    act_next = act_reg;
    cnt_next = 16'h0000;
    if (act_reg != 4'h0)
    begin
      cnt_next = cnt_reg + 16'h0001;
      if (cnt_reg == 16'(WIDTH - 1))
        act_next = 4'h0;
    end
    else if (sub.pulse_go)
      act_next = sub.pulse_sel;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      act_reg <= 4'h0;
      cnt_reg <= 16'h0000;
    end
    else
    begin
      act_reg <= act_next;
      cnt_reg <= cnt_next;
    end
  end

  assign sub.pulse_act = act_reg;
endmodule
`default_nettype wire

// File: logic/kbc_cmd_decoder.sv
/*
  kbc_cmd_decoder: host command interpreter of the keyboard and pointer
  controller, with its input and output buffers, status byte, command
  byte and output port.
  assumes host strobes last one clock, and line pins are open drain:
  an enable pulls the line low.
*/
`timescale 1ns/1ps
`default_nettype none
module kbc_cmd_decoder #(
  parameter int unsigned SETTLE = kbc_pkg::SETTLE_CYC,
  parameter int unsigned PULSE  = kbc_pkg::PULSE_CYC
)(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // host data and command/status ports
  input  wire logic       host_wr,
  input  wire logic       host_wr_cmd,
  input  wire logic [7:0] host_wdata,
  input  wire logic       host_rd_data,
  output logic      [7:0] host_rdata,
  output logic      [7:0] host_status,
  output logic            keyboard_interrupt_line,
  output logic            pointer_interrupt_line,
  // bytes toward the devices
  output logic            kbd_tx_valid,
  output logic      [7:0] kbd_tx_data,
  output logic            pnt_tx_valid,
  output logic      [7:0] pnt_tx_data,
  output logic      [7:0] cmd_byte,
  // keyboard lines
  input  wire logic       kbd_clk_in,
  output logic            kbd_clk_out,
  output logic            kbd_clk_oe,
  input  wire logic       kbd_dat_in,
  output logic            kbd_dat_out,
  output logic            kbd_dat_oe,
  // pointer lines
  input  wire logic       pnt_clk_in,
  output logic            pnt_clk_out,
  output logic            pnt_clk_oe,
  input  wire logic       pnt_dat_in,
  output logic            pnt_dat_out,
  output logic            pnt_dat_oe,
  // ports
  input  wire logic [7:0] in_port,
  input  wire logic [1:0] test_in,
  output logic      [7:0] out_port
);
  import kbc_pkg::*;

  kbc_sub_if sub ();

  logic [13:0] s1_reg, s2_reg;
  logic [7:0]  in_s;
  logic [1:0]  tst_s;
  logic [7:0]  ib_reg, ib_next, ob_reg, ob_next, cb_reg, cb_next;
  logic [7:0]  op_reg, op_next, txd_reg, txd_next, ob_val;
  logic        ibf_reg, ibf_next, cd_reg, cd_next, obf_reg, obf_next;
  logic        src_reg, src_next, tsel_reg, tsel_next;
  logic        ktx_reg, ktx_next, ptx_reg, ptx_next;
  logic        take, ob_load, ob_pnt, test_k, test_p;
  logic [3:0]  shi_reg, shi_next, slo_reg, slo_next;
  poll_e       poll_reg, poll_next;
  pend_e       pend_reg, pend_next;
  ctl_e        st_reg, st_next;

  // only the second stage is read
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_reg <= 14'h0000;
      s2_reg <= 14'h0000;
    end
    else
    begin
      s1_reg <= {in_port, test_in, kbd_clk_in, kbd_dat_in,
                 pnt_clk_in, pnt_dat_in};
      s2_reg <= s1_reg;
    end
  end
  assign in_s  = s2_reg[13:6];
  assign tst_s = s2_reg[5:4];

  // the tester owns the line pair it is checking
  assign test_k        = (st_reg == S_TEST) && !tsel_reg;
  assign test_p        = (st_reg == S_TEST) && tsel_reg;
  assign sub.test_clk  = tsel_reg ? s2_reg[1] : s2_reg[3];
  assign sub.test_dat  = tsel_reg ? s2_reg[0] : s2_reg[2];
  assign sub.pulse_sel = ~ib_reg[3:0];
  assign take          = ibf_reg && (st_reg == S_IDLE);

  always_comb
  begin
    ib_next     = ib_reg;
    ibf_next    = ibf_reg;
    cd_next     = cd_reg;
    ob_next     = ob_reg;
    obf_next    = obf_reg;
    src_next    = src_reg;
    cb_next     = cb_reg;
    op_next     = op_reg;
    txd_next    = txd_reg;
    tsel_next   = tsel_reg;
    poll_next   = poll_reg;
    pend_next   = pend_reg;
    st_next     = st_reg;
    ktx_next    = 1'b0;
    ptx_next    = 1'b0;
    ob_load     = 1'b0;
    ob_val      = ob_reg;
    ob_pnt      = 1'b0;
    sub.test_go = 1'b0;
    sub.pulse_go = 1'b0;
    shi_next    = (poll_reg == POLL_HI) ? in_s[7:4] : shi_reg;
    slo_next    = (poll_reg == POLL_LO) ? in_s[3:0] : slo_reg;
    if (take)
    begin
      ibf_next = 1'b0;
      if (cd_reg)
      begin
        // any new command ends polling and cancels a waiting argument
        poll_next = POLL_OFF;
        pend_next = PEND_NONE;
        case (ib_reg)
          CMD_PTEST:
          begin
            sub.test_go = 1'b1;
            tsel_next   = 1'b1;
            st_next     = S_TEST;
          end
          CMD_KTEST:
          begin
            sub.test_go = 1'b1;
            tsel_next   = 1'b0;
            st_next     = S_TEST;
          end
          CMD_INIT:
          begin
            cb_next[CB_KBD_DIS] = 1'b1;
            cb_next[CB_PNT_DIS] = 1'b1;
            ob_load = 1'b1;
            ob_val  = INIT_REPLY;
          end
          CMD_KDIS: cb_next[CB_KBD_DIS] = 1'b1;
          CMD_KEN:  cb_next[CB_KBD_DIS] = 1'b0;
          CMD_RDIN:
          begin
            ob_load = 1'b1;
            ob_val  = in_s;
          end
          CMD_POLLH: poll_next = POLL_HI;
          CMD_POLLL: poll_next = POLL_LO;
          CMD_RDOUT:
          begin
            ob_load = 1'b1;
            ob_val  = op_reg;
          end
          CMD_WROUT: pend_next = PEND_WROUT;
          CMD_ECHOK: pend_next = PEND_ECHOK;
          CMD_ECHOP: pend_next = PEND_ECHOP;
          CMD_WRPNT: pend_next = PEND_WRPNT;
          CMD_RDTST:
          begin
            ob_load = 1'b1;
            ob_val  = {6'h00, tst_s};
          end
          // unknown codes fall through, leaving buffers, command byte and output port unchanged
          default: sub.pulse_go = (ib_reg[7:4] == CMD_PULSE);
        endcase
      end
      else
      begin
        pend_next = PEND_NONE;
        txd_next  = ib_reg;
        case (pend_reg)
          PEND_WROUT: op_next[OP_GATE] = ib_reg[OP_GATE];
          PEND_ECHOK:
          begin
            ob_load = 1'b1;
            ob_val  = ib_reg;
          end
          PEND_ECHOP:
          begin
            ob_load = 1'b1;
            ob_val  = ib_reg;
            ob_pnt  = 1'b1;
          end
          PEND_WRPNT: ptx_next = 1'b1;
          default:    ktx_next = 1'b1;
        endcase
      end
    end
    if (sub.test_done)
    begin
      ob_load = 1'b1;
      ob_val  = sub.test_code;
      st_next = S_IDLE;
    end
    // a load in the same cycle as the host read keeps the buffer full
    if (ob_load)
    begin
      ob_next  = ob_val;
      obf_next = 1'b1;
      src_next = ob_pnt;
    end
    else if (host_rd_data)
      obf_next = 1'b0;
    // a new write beats the take of the old byte
    if (host_wr)
    begin
      ib_next  = host_wdata;
      ibf_next = 1'b1;
      cd_next  = host_wr_cmd;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ib_reg   <= 8'h00;
      ibf_reg  <= 1'b0;
      cd_reg   <= 1'b0;
      ob_reg   <= 8'h00;
      obf_reg  <= 1'b0;
      src_reg  <= 1'b0;
      cb_reg   <= CB_RST;
      op_reg   <= OP_RST;
      txd_reg  <= 8'h00;
      tsel_reg <= 1'b0;
      ktx_reg  <= 1'b0;
      ptx_reg  <= 1'b0;
      shi_reg  <= 4'h0;
      slo_reg  <= 4'h0;
      poll_reg <= POLL_OFF;
      pend_reg <= PEND_NONE;
      st_reg   <= S_IDLE;
    end
    else
    begin
      ib_reg   <= ib_next;
      ibf_reg  <= ibf_next;
      cd_reg   <= cd_next;
      ob_reg   <= ob_next;
      obf_reg  <= obf_next;
      src_reg  <= src_next;
      cb_reg   <= cb_next;
      op_reg   <= op_next;
      txd_reg  <= txd_next;
      tsel_reg <= tsel_next;
      ktx_reg  <= ktx_next;
      ptx_reg  <= ptx_next;
      shi_reg  <= shi_next;
      slo_reg  <= slo_next;
      poll_reg <= poll_next;
      pend_reg <= pend_next;
      st_reg   <= st_next;
    end
  end

  kbc_line_tester #(.SETTLE(SETTLE)) u_tester (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .sub     (sub.tst)
  );

  kbc_pulse_gen #(.WIDTH(PULSE)) u_pulse (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .sub     (sub.pls)
  );

  // poll-low hides the buffer flags while it runs
  assign host_status = {shi_reg, (poll_reg == POLL_LO) ? slo_reg :
                        {cd_reg, 1'b0, ibf_reg, obf_reg}};
  assign host_rdata  = ob_reg;
  assign keyboard_interrupt_line = obf_reg && !src_reg && cb_reg[CB_KBD_INT];
  assign pointer_interrupt_line  = obf_reg && src_reg && cb_reg[CB_PNT_INT];
  assign kbd_tx_valid = ktx_reg;
  assign kbd_tx_data  = txd_reg;
  assign pnt_tx_valid = ptx_reg;
  assign pnt_tx_data  = txd_reg;
  assign cmd_byte     = cb_reg;
  assign out_port     = op_reg & ~{4'h0, sub.pulse_act};
  assign kbd_clk_out  = 1'b0;
  assign kbd_dat_out  = 1'b0;
  assign pnt_clk_out  = 1'b0;
  assign pnt_dat_out  = 1'b0;
  assign kbd_clk_oe   = test_k ? sub.test_drv : cb_reg[CB_KBD_DIS];
  assign kbd_dat_oe   = test_k && sub.test_drv;
  assign pnt_clk_oe   = test_p ? sub.test_drv : cb_reg[CB_PNT_DIS];
  assign pnt_dat_oe   = test_p && sub.test_drv;

  // checks
  localparam int TEST_MAX = 2 * SETTLE + 4;
  logic [15:0] lo_cnt_reg, lo_cnt_next;
  assign lo_cnt_next = out_port[OP_SYSRST] ? 16'h0000 : lo_cnt_reg + 16'h0001;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      lo_cnt_reg <= 16'h0000;
    else
      lo_cnt_reg <= lo_cnt_next;
  end

  default clocking cb_chk @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_cmd(logic [7:0] c);
    take && cd_reg && (ib_reg == c);
  endsequence
  sequence s_arg(pend_e p);
    take && !cd_reg && (pend_reg == p);
  endsequence

  chk_line_finish: assert property (s_cmd(CMD_PTEST) or s_cmd(CMD_KTEST)
    |-> ##[2:TEST_MAX] sub.test_done)
    else $error("line test did not finish");
  chk_line_code: assert property (sub.test_done |=> obf_reg &&
    ob_reg == $past(sub.test_code) && ob_reg <= LT_DAT_HI)
    else $error("line test code bad");
  chk_init_reply: assert property (s_cmd(CMD_INIT) |=> obf_reg &&
    ob_reg == INIT_REPLY && cb_reg[5:4] == 2'b11)
    else $error("init reply wrong");
  chk_kbd_off: assert property (s_cmd(CMD_KDIS) |=> cb_reg[CB_KBD_DIS])
    else $error("keyboard not disabled");
  chk_kbd_on: assert property (s_cmd(CMD_KEN) |=> !cb_reg[CB_KBD_DIS])
    else $error("keyboard not enabled");
  chk_read_in: assert property (s_cmd(CMD_RDIN) |=> obf_reg &&
    ob_reg == $past(in_s))
    else $error("input port read wrong");
  chk_poll_high: assert property (poll_reg == POLL_HI
    |=> host_status[7:4] == $past(in_s[7:4]))
    else $error("poll high not mirrored");
  chk_poll_low: assert property (poll_reg == POLL_LO ##1 poll_reg == POLL_LO
    |-> host_status[3:0] == $past(in_s[3:0]))
    else $error("poll low not mirrored");
  chk_read_out: assert property (s_cmd(CMD_RDOUT) |=> obf_reg &&
    ob_reg == $past(op_reg))
    else $error("output port read wrong");
  chk_out_bit1: assert property (s_arg(PEND_WROUT) |=>
    op_reg[1] == $past(ib_reg[1]) && op_reg[0] == $past(op_reg[0]) &&
    op_reg[7:2] == $past(op_reg[7:2]))
    else $error("output port write wrong");
  chk_echo_kbd: assert property (s_arg(PEND_ECHOK) |=> ob_reg == $past(ib_reg)
    && keyboard_interrupt_line == cb_reg[CB_KBD_INT])
    else $error("keyboard echo wrong");
  chk_echo_pnt: assert property (s_arg(PEND_ECHOP) |=> ob_reg == $past(ib_reg)
    && pointer_interrupt_line == cb_reg[CB_PNT_INT])
    else $error("pointer echo wrong");
  chk_pnt_fwd: assert property (s_arg(PEND_WRPNT) |=> pnt_tx_valid &&
    !kbd_tx_valid && pnt_tx_data == $past(ib_reg))
    else $error("pointer byte not forwarded");
  chk_test_in: assert property (s_cmd(CMD_RDTST) |=>
    ob_reg == {6'h00, $past(tst_s)})
    else $error("test inputs wrong");
  chk_pulse_cause: assert property ($fell(out_port[OP_SYSRST]) |->
    $past(sub.pulse_go && sub.pulse_sel[0]))
    else $error("reset pulse without command");
  chk_pulse_len: assert property ($rose(out_port[OP_SYSRST]) |->
    lo_cnt_reg == 16'(PULSE))
    else $error("reset pulse length wrong");
  chk_cmd_flag: assert property (host_wr && host_wr_cmd |=> cd_reg &&
    ibf_reg && ib_reg == $past(host_wdata))
    else $error("command write not flagged");
  chk_obf_drop: assert property (host_rd_data && !ob_load |=> !obf_reg)
    else $error("output full not cleared");
  chk_ibf_drop: assert property (take && !host_wr |=> !ibf_reg)
    else $error("input full not cleared");
  chk_pnt_inhibit: assert property (cb_reg[CB_PNT_DIS] && !test_p
    |-> pnt_clk_oe)
    else $error("pointer clock not held");
  chk_unknown: assert property (take && cd_reg && !cmd_known(ib_reg) |=>
    $stable(ob_reg) && $stable(cb_reg) && $stable(op_reg))
    else $error("unknown command acted");
endmodule
`default_nettype wire

// File: test/kbc_line_model.sv
/*
  kbc_line_model: one open-drain clock/data pair with pull-ups, standing
  in for the keyboard or pointer at the far end of its cable.
  assumes an enable high pulls the line low.
*/
`timescale 1ns/1ps
`default_nettype none
module kbc_line_model (
  // controls
  input  wire logic oe_clk,
  input  wire logic oe_dat,
  input  wire logic clk_stuck_lo,
  // line levels
  output logic      clk_lvl,
  output logic      dat_lvl
);
  // pull-up wins unless someone pulls; a fault pins clock low
  assign clk_lvl = !(oe_clk || clk_stuck_lo);
  assign dat_lvl = !oe_dat;
endmodule
`default_nettype wire

// File: test/tb.sv
/*
  tb: self-checking bench of the command decoder.
  assumes short SETTLE and PULSE values and pulled-up line models.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import kbc_pkg::*;
  logic       clk_sys = 0, rst_b = 0, host_wr = 0, host_wr_cmd = 0;
  logic       host_rd_data = 0, pnt_stuck = 0;
  logic [7:0] host_wdata = 8'h00, in_port = 8'hA5;
  logic [1:0] test_in = 2'h2;
  int         failures = 0, n_checks = 0;
  wire logic [7:0] host_rdata, host_status, pnt_tx_data, cmd_byte, out_port;
  wire logic [7:0] kbd_tx_data;
  wire logic [3:0] line_out;
  wire logic  kc, kd, pc, pd, kco, kdo, pco, pdo;
  wire logic  kbd_tx_valid, pnt_tx_valid, k_int, p_int;
  kbc_cmd_decoder #(.SETTLE(4), .PULSE(4)) u_dut (.clk_sys, .rst_b,
    .host_wr, .host_wr_cmd, .host_wdata, .host_rd_data, .host_rdata,
    .host_status, .keyboard_interrupt_line(k_int),
    .pointer_interrupt_line(p_int), .kbd_tx_valid, .kbd_tx_data,
    .pnt_tx_valid, .pnt_tx_data, .cmd_byte, .kbd_clk_in(kc),
    .kbd_clk_out(line_out[3]), .kbd_clk_oe(kco), .kbd_dat_in(kd),
    .kbd_dat_out(line_out[2]), .kbd_dat_oe(kdo), .pnt_clk_in(pc),
    .pnt_clk_out(line_out[1]), .pnt_clk_oe(pco), .pnt_dat_in(pd),
    .pnt_dat_out(line_out[0]), .pnt_dat_oe(pdo), .in_port, .test_in,
    .out_port);
  kbc_line_model u_kbd (.oe_clk(kco), .oe_dat(kdo), .clk_stuck_lo(1'b0),
    .clk_lvl(kc), .dat_lvl(kd));
  kbc_line_model u_pnt (.oe_clk(pco), .oe_dat(pdo), .clk_stuck_lo(pnt_stuck),
    .clk_lvl(pc), .dat_lvl(pd));
  always #50 clk_sys = !clk_sys;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle strobe, then two cycles for the answer to land
  // put returns one cycle after the strobe, before the byte is taken
  task automatic put(input logic cmd, input logic [7:0] b);
    @(negedge clk_sys);
    {host_wr, host_wr_cmd, host_wdata} = {1'b1, cmd, b};
    @(negedge clk_sys);
    host_wr = 0;
  endtask
  task automatic wr(input logic cmd, input logic [7:0] b);
    put(cmd, b);
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic t_basic;
    wr(1, CMD_INIT);
    chk(host_rdata, INIT_REPLY);
    chk({6'h00, cmd_byte[5:4]}, 8'h03);
    chk({7'h00, pco}, 8'h01);
    chk({4'h0, line_out}, 8'h00);
    chk(host_status & 8'h0B, 8'h09);
    host_rd_data = 1;
    @(negedge clk_sys);
    host_rd_data = 0;
    @(negedge clk_sys);
    chk({7'h00, host_status[0]}, 8'h00);
    wr(1, 8'h01);
    chk(host_rdata, INIT_REPLY);
    chk(cmd_byte, 8'h30);
    chk(out_port, 8'h0F);
    wr(1, CMD_KEN);
    chk({7'h00, cmd_byte[4]}, 8'h00);
    chk({7'h00, kco}, 8'h00);
  endtask
  task automatic t_ports;
    wr(1, CMD_RDIN);
    chk(host_rdata, 8'hA5);
    wr(1, CMD_POLLH);
    chk({4'h0, host_status[7:4]}, 8'h0A);
    wr(1, CMD_POLLL);
    chk({4'h0, host_status[3:0]}, 8'h05);
    wr(1, CMD_WROUT);
    wr(0, 8'h00);
    wr(1, CMD_RDOUT);
    chk(host_rdata, 8'h0D);
    wr(1, CMD_RDTST);
    chk(host_rdata, 8'h02);
    wr(1, CMD_KDIS);
    chk({7'h00, cmd_byte[4]}, 8'h01);
    chk({7'h00, kco}, 8'h01);
  endtask
  task automatic t_more;
    wr(1, 8'hFE);
    chk(out_port, 8'h0C);
    repeat (6) @(negedge clk_sys);
    chk(out_port, 8'h0D);
    // ones in the low nibble leave their bits alone
    wr(1, 8'hF5);
    chk(out_port, 8'h05);
    repeat (6) @(negedge clk_sys);
    chk(out_port, 8'h0D);
    wr(1, CMD_ECHOK);
    wr(0, 8'h3C);
    chk(host_rdata, 8'h3C);
    wr(1, CMD_ECHOP);
    wr(0, 8'hC3);
    chk(host_rdata, 8'hC3);
    chk({6'h00, k_int, p_int}, 8'h00);
    wr(1, CMD_WRPNT);
    wr(0, 8'h5A);
    chk(pnt_tx_data, 8'h5A);
    wr(1, CMD_KEN);
    wr(1, CMD_KTEST);
    repeat (14) @(negedge clk_sys);
    chk(host_rdata, LT_OK);
    pnt_stuck = 1;
    wr(1, CMD_PTEST);
    repeat (14) @(negedge clk_sys);
    chk(host_rdata, LT_CLK_LO);
  endtask
  // the valid strobes stand one cycle, so they are looked at right after
  task automatic t_links;
    put(0, 8'h77);
    chk(host_status & 8'h0A, 8'h02);
    @(negedge clk_sys);
    chk({6'h00, kbd_tx_valid, pnt_tx_valid}, 8'h02);
    chk(kbd_tx_data, 8'h77);
    wr(1, CMD_WRPNT);
    put(0, 8'h6B);
    @(negedge clk_sys);
    chk({6'h00, kbd_tx_valid, pnt_tx_valid}, 8'h01);
    chk(pnt_tx_data, 8'h6B);
    @(negedge clk_sys);
    chk({6'h00, kbd_tx_valid, pnt_tx_valid}, 8'h00);
  endtask
  task automatic t_reset;
    @(negedge clk_sys);
    rst_b = 0;
    repeat (2) @(negedge clk_sys);
    chk(out_port, 8'h0F);
    chk(cmd_byte, 8'h00);
    chk(host_status, 8'h00);
    chk(host_rdata, 8'h00);
    rst_b = 1;
    wr(1, CMD_RDOUT);
    chk(host_rdata, 8'h0F);
    chk({7'h00, pco}, 8'h00);
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge clk_sys);
    rst_b = 1;
    t_basic;
    t_ports;
    t_more;
    t_links;
    t_reset;
    finish_test;
  end
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    failures++;
    finish_test;
  end
endmodule
`default_nettype wire
